/* inc/uepd_pkg.sv */
package uepd_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RESUME_SE0_NS = 1344;
  localparam int unsigned RESUME_CYC = (RESUME_SE0_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [5:0] RESUME_CYC_W = 6'(RESUME_CYC);
  localparam logic [5:0] RESUME_TOL = 6'h08;
  localparam int unsigned PKT_BYTES = 64;
  localparam logic [6:0] PKT_MAX = 7'h40;
  localparam int unsigned NUM_EP = 3;
  localparam int unsigned NUM_CH = 2;
  localparam logic [7:0] ADR_EP_STAT0 = 8'h00;
  localparam logic [7:0] ADR_EP_STAT1 = 8'h04;
  localparam logic [7:0] ADR_EP_STAT2 = 8'h08;
  localparam logic [7:0] ADR_IRQ_STAT2 = 8'h0c;
  localparam logic [7:0] ADR_DMA_CON0 = 8'h10;
  localparam logic [7:0] ADR_DMA_CON1 = 8'h14;
  localparam logic [7:0] ADR_EP_CFG = 8'h18;
  localparam logic [7:0] ADR_FIFO0 = 8'h20;
  localparam logic [7:0] ADR_FIFO1 = 8'h24;
  localparam logic [7:0] ADR_FIFO2 = 8'h28;
  localparam int unsigned BIT_RX_RDY = 0;
  localparam int unsigned BIT_TX_RDY = 1;
  localparam int unsigned BIT_AWAKE = 0;
  localparam int unsigned BIT_DMA_EN = 0;
  localparam int unsigned BIT_DMA_SINGLE = 1;
  localparam int unsigned BIT_DMA_WIDE = 2;
  localparam int unsigned BIT_DMA_EP_LO = 3;
  localparam int unsigned BIT_DMA_EP_HI = 4;
  localparam int unsigned BIT_EP2_BULK = 0;
  typedef enum logic [1:0] {
    UEPD_LINE_SE0 = 2'b00,
    UEPD_LINE_J = 2'b10,
    UEPD_LINE_K = 2'b01,
    UEPD_LINE_SE1 = 2'b11
  } uepd_line_e;
  typedef enum logic [1:0] {
    UEPD_PWR_RUN = 2'b00,
    UEPD_PWR_DOWN = 2'b01,
    UEPD_PWR_WAKE = 2'b10
  } uepd_pwr_e;
endpackage

/* src/uepd_pingpong.sv */
`timescale 1ns/1ps
// Two-layer 64-byte packet buffer, fixed A/B alternation.
module uepd_pingpong (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dir_tx_i,
  input wire logic usb_wr_i,
  input wire logic [7:0] usb_data_i,
  input wire logic usb_eop_i,
  input wire logic usb_err_i,
  input wire logic usb_rd_i,
  input wire logic usb_ack_i,
  input wire logic usb_nak_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_data_i,
  input wire logic rx_clear_i,
  input wire logic tx_commit_i,
  output logic [7:0] cpu_data_o,
  output logic [7:0] usb_data_o,
  output logic usb_pkt_avail_o,
  output logic [6:0] usb_len_o,
  output logic rx_ready_o,
  output logic tx_ready_o,
  output logic irq_o,
  output logic cpu_room_o
);
  logic [7:0] mem [2][uepd_pkg::PKT_BYTES];
  logic [1:0] full;
  logic [6:0] len [2];
  logic fill_sel;
  logic drain_sel;
  logic [6:0] wptr;
  logic [6:0] rptr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_byte;

  assign wr_en = dir_tx_i ? (cpu_wr_i && !full[fill_sel]) : (usb_wr_i && !full[fill_sel]);
  assign rd_en = dir_tx_i ? (usb_rd_i && full[drain_sel]) : (cpu_rd_i && full[drain_sel]);
  assign wr_byte = dir_tx_i ? cpu_data_i : usb_data_i;

  always_ff @(posedge clk_i) begin
    if (wr_en && wptr < uepd_pkg::PKT_MAX) begin
      mem[fill_sel][wptr[5:0]] <= wr_byte;
    end
  end

  // Fill side: layer A then B then A, so packets leave in arrival order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= 7'h00;
      fill_sel <= 1'b0;
    end else if (!dir_tx_i && usb_err_i) begin
      wptr <= 7'h00; // Errored packet dropped silently
    end else if ((dir_tx_i ? tx_commit_i : usb_eop_i) && !full[fill_sel]) begin
      wptr <= 7'h00;
      fill_sel <= !fill_sel;
    end else if (wr_en && wptr < uepd_pkg::PKT_MAX) begin
      wptr <= wptr + 7'h01;
    end
  end

  // Drain side; tx keeps the layer until ACK so a retry resends it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rptr <= 7'h00;
      drain_sel <= 1'b0;
    end else if (dir_tx_i && usb_nak_i) begin
      rptr <= 7'h00;
    end else if (dir_tx_i ? (usb_ack_i && full[drain_sel])
                 : (rx_clear_i && full[drain_sel])) begin
      rptr <= 7'h00;
      drain_sel <= !drain_sel;
    end else if (rd_en && rptr < len[drain_sel]) begin
      rptr <= rptr + 7'h01;
    end
  end

  // Clear frees the read layer; ready and irq stay up while the other layer is full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full <= 2'b00;
      len[0] <= 7'h00;
      len[1] <= 7'h00;
    end else begin
      if ((dir_tx_i ? tx_commit_i : (usb_eop_i && !usb_err_i)) && !full[fill_sel]) begin
        full[fill_sel] <= 1'b1;
        len[fill_sel] <= wptr;
      end
      if (dir_tx_i ? (usb_ack_i && full[drain_sel])
          : (rx_clear_i && full[drain_sel])) begin
        full[drain_sel] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_data_o <= 8'h00;
      usb_data_o <= 8'h00;
      rx_ready_o <= 1'b0;
      tx_ready_o <= 1'b0;
      irq_o <= 1'b0;
      cpu_room_o <= 1'b0;
      usb_pkt_avail_o <= 1'b0;
      usb_len_o <= 7'h00;
    end else begin
      cpu_data_o <= mem[drain_sel][rptr[5:0]];
      usb_data_o <= mem[drain_sel][rptr[5:0]];
      usb_len_o <= len[drain_sel];
      usb_pkt_avail_o <= dir_tx_i && full[drain_sel];
      rx_ready_o <= !dir_tx_i && (full != 2'b00);
      tx_ready_o <= dir_tx_i && (full == 2'b11);
      irq_o <= dir_tx_i ? (full != 2'b11) : (full != 2'b00);
      // Receive room ends with the last byte so a demand request can drop
      cpu_room_o <= dir_tx_i ? !full[fill_sel] : (full[drain_sel] && rptr < len[drain_sel]);
    end
  end
endmodule

/* src/uepd_top.sv */
`timescale 1ns/1ps
// Function
// - Raise awake flag on resume: SE0 of about 1344 ns right after K.
// - Awake flag holds until software writes one to its status bit.
// - DMA is 8 or 16 bits wide on bulk endpoints.
// - 8-bit DMA uses low byte lanes; 16-bit on channel 0 copies the byte to the high output lane.
// - Two independent DMA channels, each demand or single mode.
// - Demand mode holds request low until the whole packet moved.
// - Single mode drops request after each byte or word unit.
// - Suspend stops the oscillator and enters power-down.
// - Resume restarts the oscillator and leaves power-down.
// - Endpoints 1 and 2 have two 64-byte layers.
// - Endpoint 4 in bulk mode also has two 64-byte layers.
// - Full received packet with end-of-packet sets receive ready and irq.
// - Next received packet goes into layer B.
// - Clear with layer B incomplete drops ready and irq.
// - Clear with layer B complete frees layer A and moves reads to B; ready and irq stay.
// - Transmit both empty: ready clear, irq asserted.
// - Transmit both layers ready: ready set, irq released.
// - No ACK keeps the packet and resends it on the next IN.
// - Receive errors give no interrupt and no handshake.
module uepd_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] usb_line_i,
  input wire logic suspend_det_i,
  input wire logic [2:0] usb_ep_i,
  input wire logic usb_wr_i,
  input wire logic [7:0] usb_data_i,
  input wire logic usb_eop_i,
  input wire logic usb_err_i,
  input wire logic usb_rd_i,
  input wire logic usb_ack_i,
  input wire logic usb_nak_i,
  output logic [7:0] usb_data_o,
  output logic usb_pkt_avail_o,
  output logic [6:0] usb_len_o,
  output logic usb_handshake_ok_o,
  input wire logic [1:0] dma_ack_n_i,
  input wire logic dma_rd_i,
  input wire logic dma_wr_i,
  input wire logic [7:0] bus_high_byte_i,
  input wire logic [7:0] muxed_bus_low_byte_i,
  output logic [7:0] bus_high_byte_o,
  output logic [7:0] muxed_bus_low_byte_o,
  output logic bus_oe_n_o,
  output logic [1:0] dma_request_n_o,
  output logic host_cpu_irq_o,
  output logic awake_o,
  output logic osc_run_o,
  output logic power_down_o
);
  localparam int unsigned NE = uepd_pkg::NUM_EP;
  localparam int unsigned NC = uepd_pkg::NUM_CH;

  function automatic logic [1:0] ep_of(input logic [7:0] adr);
    ep_of = adr[3:2];
  endfunction

  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic susp_s1;
  logic susp_s2;
  logic [1:0] ack_s1;
  logic [1:0] ack_s2;
  logic [5:0] se0_cnt;
  logic prev_k;
  logic awake;
  logic ep2_bulk;
  logic [5:0] dma_con [NC];
  logic bus_req;
  logic wb_wr;
  logic wb_rd;
  uepd_pkg::uepd_pwr_e pwr;
  logic [NE-1:0] ep_rx_clr;
  logic [NE-1:0] ep_tx_commit;
  logic [NE-1:0] ep_cpu_wr;
  logic [NE-1:0] ep_cpu_rd;
  logic [NE-1:0] ep_usb_wr;
  logic [NE-1:0] ep_usb_rd;
  logic [NE-1:0] ep_usb_ack;
  logic [NE-1:0] ep_usb_nak;
  logic [NE-1:0] ep_usb_eop;
  logic [NE-1:0] ep_rx_rdy;
  logic [NE-1:0] ep_tx_rdy;
  logic [NE-1:0] ep_irq;
  logic [NE-1:0] ep_room;
  logic [NE-1:0] ep_pkt;
  logic [NE-1:0] ep_dir_tx;
  logic [7:0] ep_cpu_q [NE];
  logic [7:0] ep_usb_q [NE];
  logic [6:0] ep_len [NE];
  logic [7:0] cpu_byte [NE];
  logic [NE-1:0] ep_dir;
  logic [NC-1:0] dma_unit;
  logic [NC-1:0] dma_busy;

  // Link pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_s1 <= 2'b10;
      line_s2 <= 2'b10;
      susp_s1 <= 1'b0;
      susp_s2 <= 1'b0;
      ack_s1 <= 2'b11;
      ack_s2 <= 2'b11;
    end else begin
      line_s1 <= usb_line_i;
      line_s2 <= line_s1;
      susp_s1 <= suspend_det_i;
      susp_s2 <= susp_s1;
      ack_s1 <= dma_ack_n_i;
      ack_s2 <= ack_s1;
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign wb_rd = bus_req && !wb_we_i;

  // Resume: SE0 measured after K, accepted near the nominal length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      se0_cnt <= 6'h00;
      prev_k <= 1'b0;
      awake <= 1'b0;
    end else begin
      if (line_s2 == uepd_pkg::UEPD_LINE_K) begin
        prev_k <= 1'b1;
      end else if (line_s2 != uepd_pkg::UEPD_LINE_SE0) begin
        prev_k <= 1'b0;
      end
      if (line_s2 == uepd_pkg::UEPD_LINE_SE0 && prev_k) begin
        if (se0_cnt != 6'h3f) begin
          se0_cnt <= se0_cnt + 6'h01;
        end
      end else begin
        se0_cnt <= 6'h00;
      end
      // Set wins over a clear in the same cycle
      if (line_s2 != uepd_pkg::UEPD_LINE_SE0 && prev_k
          && se0_cnt >= uepd_pkg::RESUME_CYC_W - uepd_pkg::RESUME_TOL
          && se0_cnt <= uepd_pkg::RESUME_CYC_W + uepd_pkg::RESUME_TOL) begin
        awake <= 1'b1;
      end else if (wb_wr && wb_adr_i == uepd_pkg::ADR_IRQ_STAT2
                   && wb_dat_i[uepd_pkg::BIT_AWAKE]) begin
        awake <= 1'b0;
      end
    end
  end

  // Oscillator gate; clock itself assumed kept alive by the pad cell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr <= uepd_pkg::UEPD_PWR_RUN;
    end else begin
      unique case (pwr)
        uepd_pkg::UEPD_PWR_RUN: if (susp_s2) pwr <= uepd_pkg::UEPD_PWR_DOWN;
        uepd_pkg::UEPD_PWR_DOWN: if (awake) pwr <= uepd_pkg::UEPD_PWR_WAKE;
        uepd_pkg::UEPD_PWR_WAKE: if (!susp_s2) pwr <= uepd_pkg::UEPD_PWR_RUN;
        default: pwr <= uepd_pkg::UEPD_PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep2_bulk <= 1'b1;
      ep_dir <= '0;
      dma_con[0] <= 6'h00;
      dma_con[1] <= 6'h00;
    end else if (wb_wr) begin
      if (wb_adr_i == uepd_pkg::ADR_EP_CFG) begin
        ep2_bulk <= wb_dat_i[uepd_pkg::BIT_EP2_BULK];
        ep_dir <= wb_dat_i[4+NE-1:4];
      end
      if (wb_adr_i == uepd_pkg::ADR_DMA_CON0) dma_con[0] <= wb_dat_i[5:0];
      if (wb_adr_i == uepd_pkg::ADR_DMA_CON1) dma_con[1] <= wb_dat_i[5:0];
    end
  end

  // Endpoints 1, 2 and bulk endpoint 4 as slots 0..2
  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_ep
      logic [1:0] ch_hit;
      logic dma_this;
      logic [NC-1:0] ch_match;
      for (genvar c = 0; c < NC; c++) begin : g_m
        assign ch_match[c] = dma_con[c][uepd_pkg::BIT_DMA_EN]
          && dma_con[c][uepd_pkg::BIT_DMA_EP_HI:uepd_pkg::BIT_DMA_EP_LO] == 2'(g)
          && !ack_s2[c];
      end
      assign dma_this = |ch_match;
      assign ch_hit = 2'(g);
      assign ep_dir_tx[g] = ep_dir[g];
      assign ep_rx_clr[g] = wb_wr && wb_adr_i == 8'(g * 4)
                            && wb_dat_i[uepd_pkg::BIT_RX_RDY];
      assign ep_tx_commit[g] = wb_wr && wb_adr_i == 8'(g * 4)
                               && wb_dat_i[uepd_pkg::BIT_TX_RDY];
      assign ep_cpu_wr[g] = (wb_wr && wb_adr_i == uepd_pkg::ADR_FIFO0 + 8'(g * 4))
                            || (dma_this && dma_wr_i);
      assign ep_cpu_rd[g] = (wb_rd && wb_adr_i == uepd_pkg::ADR_FIFO0 + 8'(g * 4))
                            || (dma_this && dma_rd_i);
      assign cpu_byte[g] = dma_this ? muxed_bus_low_byte_i : wb_dat_i[7:0];
      assign ep_usb_wr[g] = usb_wr_i && usb_ep_i == 3'(ch_hit);
      assign ep_usb_rd[g] = usb_rd_i && usb_ep_i == 3'(ch_hit);
      assign ep_usb_ack[g] = usb_ack_i && usb_ep_i == 3'(ch_hit);
      assign ep_usb_nak[g] = usb_nak_i && usb_ep_i == 3'(ch_hit);
      assign ep_usb_eop[g] = usb_eop_i && usb_ep_i == 3'(ch_hit)
                             && (g != 2 || ep2_bulk);
      uepd_pingpong u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .dir_tx_i(ep_dir_tx[g]),
        .usb_wr_i(ep_usb_wr[g]),
        .usb_data_i(usb_data_i),
        .usb_eop_i(ep_usb_eop[g]),
        .usb_err_i(usb_err_i && usb_ep_i == 3'(ch_hit)),
        .usb_rd_i(ep_usb_rd[g]),
        .usb_ack_i(ep_usb_ack[g]),
        .usb_nak_i(ep_usb_nak[g]),
        .cpu_wr_i(ep_cpu_wr[g]),
        .cpu_rd_i(ep_cpu_rd[g]),
        .cpu_data_i(cpu_byte[g]),
        .rx_clear_i(ep_rx_clr[g]),
        .tx_commit_i(ep_tx_commit[g]),
        .cpu_data_o(ep_cpu_q[g]),
        .usb_data_o(ep_usb_q[g]),
        .usb_pkt_avail_o(ep_pkt[g]),
        .usb_len_o(ep_len[g]),
        .rx_ready_o(ep_rx_rdy[g]),
        .tx_ready_o(ep_tx_rdy[g]),
        .irq_o(ep_irq[g]),
        .cpu_room_o(ep_room[g])
      );
    end
  endgenerate

  // DMA request per channel; demand holds, single drops per unit
  generate
    for (g = 0; g < NC; g++) begin : g_dma
      assign dma_busy[g] = dma_con[g][uepd_pkg::BIT_DMA_EN]
        && ep_room[dma_con[g][uepd_pkg::BIT_DMA_EP_HI:uepd_pkg::BIT_DMA_EP_LO]];
      assign dma_unit[g] = !ack_s2[g] && (dma_rd_i || dma_wr_i);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dma_request_n_o[g] <= 1'b1;
        end else if (!dma_busy[g]) begin
          dma_request_n_o[g] <= 1'b1;
        end else if (dma_con[g][uepd_pkg::BIT_DMA_SINGLE] && dma_unit[g]) begin
          dma_request_n_o[g] <= 1'b1;
        end else begin
          dma_request_n_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        uepd_pkg::ADR_EP_STAT0, uepd_pkg::ADR_EP_STAT1, uepd_pkg::ADR_EP_STAT2:
          wb_dat_o <= {30'h0, ep_tx_rdy[ep_of(wb_adr_i)], ep_rx_rdy[ep_of(wb_adr_i)]};
        uepd_pkg::ADR_IRQ_STAT2: wb_dat_o <= {31'h0, awake};
        uepd_pkg::ADR_DMA_CON0: wb_dat_o <= {26'h0, dma_con[0]};
        uepd_pkg::ADR_DMA_CON1: wb_dat_o <= {26'h0, dma_con[1]};
        uepd_pkg::ADR_EP_CFG: wb_dat_o <= {25'h0, ep_dir, 3'h0, ep2_bulk};
        uepd_pkg::ADR_FIFO0, uepd_pkg::ADR_FIFO1, uepd_pkg::ADR_FIFO2:
          wb_dat_o <= {24'h0, ep_cpu_q[ep_of(wb_adr_i) - 2'h0]};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  logic [1:0] usb_slot;
  assign usb_slot = usb_ep_i[1:0] < 2'(NE) ? usb_ep_i[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      usb_data_o <= 8'h00;
      usb_pkt_avail_o <= 1'b0;
      usb_len_o <= 7'h00;
      usb_handshake_ok_o <= 1'b0;
      host_cpu_irq_o <= 1'b0;
      awake_o <= 1'b0;
      osc_run_o <= 1'b1;
      power_down_o <= 1'b0;
      bus_high_byte_o <= 8'h00;
      muxed_bus_low_byte_o <= 8'h00;
      bus_oe_n_o <= 1'b1;
    end else begin
      usb_data_o <= ep_usb_q[usb_slot];
      usb_pkt_avail_o <= ep_pkt[usb_slot];
      usb_len_o <= ep_len[usb_slot];
      usb_handshake_ok_o <= usb_eop_i && !usb_err_i;
      host_cpu_irq_o <= (|ep_irq) || awake;
      awake_o <= awake;
      osc_run_o <= pwr != uepd_pkg::UEPD_PWR_DOWN;
      power_down_o <= pwr == uepd_pkg::UEPD_PWR_DOWN;
      muxed_bus_low_byte_o <= ep_cpu_q[usb_slot];
      bus_high_byte_o <= dma_con[0][uepd_pkg::BIT_DMA_WIDE] ? ep_cpu_q[usb_slot] : 8'h00;
      bus_oe_n_o <= !(dma_rd_i && (ack_s2 != 2'b11));
    end
  end

  chk_awake_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    awake && !(wb_wr && wb_adr_i == uepd_pkg::ADR_IRQ_STAT2) |=> awake)
    else $error("awake flag dropped without write");
  chk_pwr_down: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr == uepd_pkg::UEPD_PWR_RUN && susp_s2 |=> pwr == uepd_pkg::UEPD_PWR_DOWN ##1 !osc_run_o)
    else $error("suspend did not stop oscillator");
  chk_pwr_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr == uepd_pkg::UEPD_PWR_DOWN && awake |=> pwr == uepd_pkg::UEPD_PWR_WAKE)
    else $error("resume did not restart");
  chk_dma_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !dma_busy[0] |=> dma_request_n_o[0])
    else $error("request without packet");
  chk_dma_single: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_con[1][uepd_pkg::BIT_DMA_SINGLE] && dma_unit[1] |=> dma_request_n_o[1])
    else $error("single mode kept request");
  chk_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    awake |=> host_cpu_irq_o)
    else $error("irq missing for awake");
  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
  chk_hs_err: assert property (@(posedge clk_i) disable iff (rst_i)
    usb_err_i |=> !usb_handshake_ok_o)
    else $error("handshake on error");
endmodule

/* verif/uepd_dma_model.sv */
`timescale 1ns/1ps
// External DMA controller: one unit per acknowledge, optional idle gap before each unit
module uepd_dma_model (
  input wire logic clk_i,
  input wire logic [1:0] dma_request_n_i,
  input wire logic [7:0] low_byte_i,
  output logic [1:0] dma_ack_n_o,
  output logic dma_rd_o
);
  logic [7:0] got_q[$];
  int drops;
  int stalls;
  initial begin
    dma_ack_n_o = 2'b11;
    dma_rd_o = 1'b0;
    drops = 0;
    stalls = 0;
  end
  // Gap models a slow controller; the device must keep its request meanwhile
  task automatic run(input int ch, input int n, input int gap);
    int k;
    bit seen;
    got_q.delete();
    drops = 0;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (dma_request_n_i[ch] !== 1'b0 && k < 200) begin
        @(posedge clk_i);
        k++;
      end
      if (k == 200) stalls++;
      repeat (gap) @(posedge clk_i);
      dma_ack_n_o[ch] <= 1'b0;
      // Acknowledge passes two sync stages before the strobe counts
      repeat (2) @(posedge clk_i);
      dma_rd_o <= 1'b1;
      @(posedge clk_i);
      got_q.push_back(low_byte_i);
      dma_rd_o <= 1'b0;
      dma_ack_n_o[ch] <= 1'b1;
      seen = 1'b0;
      repeat (3) begin
        @(posedge clk_i);
        if (dma_request_n_i[ch] === 1'b1) seen = 1'b1;
      end
      if (seen) drops++;
    end
  endtask
endmodule

/* verif/tb_usb_ep_double_buffer_dma.sv */
`timescale 1ns/1ps
module tb_usb_ep_double_buffer_dma;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, suspend_det_i, hs_seen;
  logic [7:0] wb_adr_i, usb_data_i, usb_data_o, bus_high_byte_o, muxed_bus_low_byte_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic [1:0] usb_line_i, dma_ack_n_i, dma_request_n_o;
  logic [2:0] usb_ep_i;
  logic [6:0] usb_len_o;
  logic usb_wr_i, usb_eop_i, usb_err_i, usb_rd_i, usb_ack_i, usb_nak_i, dma_rd_i, dma_wr_i;
  logic usb_pkt_avail_o, usb_handshake_ok_o, bus_oe_n_o, host_cpu_irq_o;
  logic awake_o, osc_run_o, power_down_o;
  int err_total, samples_checked;

  uepd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .usb_line_i(usb_line_i),
    .suspend_det_i(suspend_det_i), .usb_ep_i(usb_ep_i), .usb_wr_i(usb_wr_i),
    .usb_data_i(usb_data_i), .usb_eop_i(usb_eop_i), .usb_err_i(usb_err_i), .usb_rd_i(usb_rd_i),
    .usb_ack_i(usb_ack_i), .usb_nak_i(usb_nak_i), .usb_data_o(usb_data_o),
    .usb_pkt_avail_o(usb_pkt_avail_o), .usb_len_o(usb_len_o),
    .usb_handshake_ok_o(usb_handshake_ok_o), .dma_ack_n_i(dma_ack_n_i), .dma_rd_i(dma_rd_i),
    .dma_wr_i(dma_wr_i), .bus_high_byte_i(8'h5a), .muxed_bus_low_byte_i(8'ha5),
    .bus_high_byte_o(bus_high_byte_o), .muxed_bus_low_byte_o(muxed_bus_low_byte_o),
    .bus_oe_n_o(bus_oe_n_o), .dma_request_n_o(dma_request_n_o), .host_cpu_irq_o(host_cpu_irq_o),
    .awake_o(awake_o), .osc_run_o(osc_run_o), .power_down_o(power_down_o));
  uepd_dma_model dma (.clk_i(clk_i), .dma_request_n_i(dma_request_n_o),
    .low_byte_i(muxed_bus_low_byte_o), .dma_ack_n_o(dma_ack_n_i), .dma_rd_o(dma_rd_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (usb_handshake_ok_o === 1'b1) hs_seen <= 1'b1;

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) chk("bus ack", 1, 0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rx(input logic [2:0] ep, input int len, input logic [7:0] b, input logic bad);
    usb_ep_i <= ep;
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      usb_wr_i <= 1'b1;
      usb_data_i <= b + 8'(i);
    end
    @(posedge clk_i);
    usb_wr_i <= 1'b0;
    usb_eop_i <= !bad;
    usb_err_i <= bad;
    @(posedge clk_i);
    usb_eop_i <= 1'b0;
    usb_err_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task rdfifo(input logic [7:0] a, input int len, input logic [7:0] b);
    for (int i = 0; i < len; i++) begin
      wb(1'b0, a, 32'h0);
      chk("fifo byte", {24'h0, b + 8'(i)}, {24'h0, rd[7:0]});
    end
  endtask
  task txfill(input int len, input logic [7:0] b);
    for (int i = 0; i < len; i++) wb(1'b1, uepd_pkg::ADR_FIFO1, {24'h0, b + 8'(i)});
    wb(1'b1, uepd_pkg::ADR_EP_STAT1, 32'h2);
  endtask
  task usbtx(input int len, input logic [7:0] b);
    for (int i = 0; i < len; i++) begin
      repeat (3) @(posedge clk_i);
      chk("usb byte", {24'h0, b + 8'(i)}, {24'h0, usb_data_o});
      @(posedge clk_i);
      usb_rd_i <= 1'b1;
      @(posedge clk_i);
      usb_rd_i <= 1'b0;
    end
  endtask
  task line(input logic [1:0] v, input int n);
    usb_line_i <= v;
    repeat (n) @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    chk("watchdog", 0, 1);
    end_of_test();
  end

  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, suspend_det_i, hs_seen} = 6'h20;
    {usb_wr_i, usb_eop_i, usb_err_i, usb_rd_i, usb_ack_i, usb_nak_i, dma_wr_i} = 7'h0;
    {wb_adr_i, wb_dat_i, usb_data_i, usb_ep_i, err_total, samples_checked} = '0;
    wb_sel_i = 4'hf;
    usb_line_i = 2'b10;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset irq", 0, host_cpu_irq_o);
    chk("reset dma request", 3, dma_request_n_o);
    chk("bus released", 1, bus_oe_n_o);
    rx(3'h0, 5, 8'h80, 1'b1);
    chk("irq after error", 0, host_cpu_irq_o);
    chk("handshake after error", 0, hs_seen);
    rx(3'h0, 64, 8'h00, 1'b0);
    chk("rx irq", 1, host_cpu_irq_o);
    chk("handshake good", 1, hs_seen);
    wb(1'b0, uepd_pkg::ADR_EP_STAT0, 32'h0);
    chk("rx ready", 1, rd[0]);
    rdfifo(uepd_pkg::ADR_FIFO0, 64, 8'h00);
    wb(1'b1, uepd_pkg::ADR_EP_STAT0, 32'h1);
    wb(1'b0, uepd_pkg::ADR_EP_STAT0, 32'h0);
    chk("rx ready cleared", 0, rd[0]);
    chk("irq cleared", 0, host_cpu_irq_o);
    rx(3'h0, 4, 8'ha0, 1'b0);
    rx(3'h0, 4, 8'hc0, 1'b0);
    rdfifo(uepd_pkg::ADR_FIFO0, 4, 8'ha0);
    wb(1'b1, uepd_pkg::ADR_EP_STAT0, 32'h1);
    wb(1'b0, uepd_pkg::ADR_EP_STAT0, 32'h0);
    chk("rx ready kept", 1, rd[0]);
    chk("irq kept", 1, host_cpu_irq_o);
    rdfifo(uepd_pkg::ADR_FIFO0, 4, 8'hc0);
    $display("test receive done");
    reset();
    wb(1'b1, uepd_pkg::ADR_EP_CFG, 32'h21);
    repeat (2) @(posedge clk_i);
    chk("tx empty irq", 1, host_cpu_irq_o);
    txfill(8, 8'h10);
    chk("one layer irq", 1, host_cpu_irq_o);
    txfill(5, 8'h60);
    wb(1'b0, uepd_pkg::ADR_EP_STAT1, 32'h0);
    chk("tx ready full", 1, rd[1]);
    chk("tx full irq", 0, host_cpu_irq_o);
    usb_ep_i <= 3'h1;
    repeat (2) @(posedge clk_i);
    chk("tx length A", 8, usb_len_o);
    chk("tx avail", 1, usb_pkt_avail_o);
    usbtx(3, 8'h10);
    @(posedge clk_i);
    usb_nak_i <= 1'b1;
    @(posedge clk_i);
    usb_nak_i <= 1'b0;
    usbtx(8, 8'h10);
    usb_ack_i <= 1'b1;
    @(posedge clk_i);
    usb_ack_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("tx length B", 5, usb_len_o);
    chk("irq after ack", 1, host_cpu_irq_o);
    usbtx(5, 8'h60);
    $display("test transmit done");
    reset();
    wb(1'b1, uepd_pkg::ADR_DMA_CON0, 32'h1);
    rx(3'h0, 4, 8'h30, 1'b0);
    dma.run(0, 4, 2);
    for (int i = 0; i < 4; i++) chk("dma byte", 8'h30 + 8'(i), dma.got_q[i]);
    chk("demand drops", 1, dma.drops);
    chk("other channel idle", 1, dma_request_n_o[1]);
    chk("high lane idle", 0, bus_high_byte_o);
    wb(1'b1, uepd_pkg::ADR_EP_STAT0, 32'h1);
    wb(1'b1, uepd_pkg::ADR_DMA_CON0, 32'h0);
    wb(1'b1, uepd_pkg::ADR_DMA_CON1, 32'h3);
    rx(3'h0, 3, 8'h50, 1'b0);
    dma.run(1, 3, 0);
    for (int i = 0; i < 3; i++) chk("dma byte", 8'h50 + 8'(i), dma.got_q[i]);
    chk("single drops", 3, dma.drops);
    chk("dma waits", 0, dma.stalls);
    $display("test dma done");
    reset();
    suspend_det_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("osc stopped", 0, osc_run_o);
    chk("power down", 1, power_down_o);
    line(2'b01, 10);
    line(2'b00, 10);
    line(2'b10, 8);
    chk("short se0 no wake", 0, awake_o);
    suspend_det_i <= 1'b0;
    line(2'b01, 10);
    line(2'b00, uepd_pkg::RESUME_CYC);
    line(2'b10, 8);
    chk("awake", 1, awake_o);
    chk("osc restarted", 1, osc_run_o);
    chk("power up", 0, power_down_o);
    wb(1'b0, uepd_pkg::ADR_IRQ_STAT2, 32'h0);
    chk("awake held", 1, rd[0]);
    wb(1'b1, uepd_pkg::ADR_IRQ_STAT2, 32'h1);
    wb(1'b0, uepd_pkg::ADR_IRQ_STAT2, 32'h0);
    chk("awake cleared", 0, rd[0]);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped read", 0, rd);
    $display("test power done");
    end_of_test();
  end
endmodule
